// File: bench/tb_top.sv
/*
  Self-checking bench for the frame timing front end, fed by the far-end model.
  Assumes the package and the design files are compiled before it.
*/
`timescale 1ns/100ps
module tb_top;
  // ==========================================================================
  // Signals
  localparam int HALF = 4;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_ce = 1'b1;
  logic        ies = 1'b0, frame_pulse_width_select = 1'b0, ocs = 1'b0, sty = 1'b0;
  logic [1:0]  rate = 2'h0;
  logic [31:0] bp_tx = 32'h0, lo_tx = 32'h0;
  logic        mclk, fpin, mark, clk8, fp8, clk16, fp16, style, locked, fstart, strobe;
  logic [31:0] bp_in, lo_in, bp_rx, lo_rx, bp_out, lo_out, e_bprx, e_lorx, e_bpo, e_loo;
  logic [7:0]  chan, last_ch;
  logic [2:0]  bitn, last_bit;
  logic        pend = 1'b0, c8q = 1'b0, c16q = 1'b0;
  logic        hold8, hold16;
  int          n_fail = 0, checks_done = 0, seed = 47300, cycles = 0;
  int          frames = 0, lag = 0, f_cyc, n_str, n_r8, n_r16, w8, w16;

  always #4 i_clk = ~i_clk;

  tft_far_end #(.HALF(HALF)) i_far (
    .i_clk(i_clk), .i_edge_sel(ies), .i_wide(frame_pulse_width_select), .i_active_high(sty), .i_rate(rate),
    .o_master_clock(mclk), .o_frame_pulse(fpin), .o_frame_mark(mark),
    .o_backplane_serial(bp_in), .o_local_serial(lo_in)
  );

  tft_frame_timing i_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_master_clock_in(mclk),
    .i_frame_pulse_in(fpin), .i_input_clock_edge_select(ies),
    .i_frame_pulse_width_select(frame_pulse_width_select), .i_output_clock_edge_select(ocs),
    .i_stream_rate(rate), .i_backplane_serial_in(bp_in), .i_local_serial_in(lo_in),
    .i_backplane_tx_bits(bp_tx), .i_local_tx_bits(lo_tx), .o_backplane_rx_bits(bp_rx),
    .o_local_rx_bits(lo_rx), .o_backplane_serial_out(bp_out), .o_local_serial_out(lo_out),
    .o_clock_out_8m(clk8), .o_frame_pulse_out_8m(fp8), .o_clock_out_16m(clk16),
    .o_frame_pulse_out_16m(fp16), .o_style_active_high(style), .o_locked(locked),
    .o_frame_start(fstart), .o_bit_strobe(strobe), .o_channel(chan), .o_bit(bitn)
  );

  // ==========================================================================
  // Expectations and reporting
  function automatic int exp_strobes(logic [1:0] r);
    return 256 << r;
  endfunction

  function automatic int exp_width(logic wide, int narrow_halves);
    return (wide ? 2 : 1) * narrow_halves * HALF;
  endfunction

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==========================================================================
  // Monitor: lanes on every strobe, frame figures at every frame start but the first
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 90000) begin
      n_fail++;
      results();
    end
    if (i_rst) begin
      frames = 0;
      pend = 1'b0;
    end else begin
      if (pend) begin
        chk("backplane rx", e_bprx, bp_rx);
        chk("local rx", e_lorx, lo_rx);
        chk("backplane out", e_bpo, bp_out);
        chk("local out", e_loo, lo_out);
      end
      pend = strobe;
      e_bprx = bp_in;
      e_lorx = lo_in;
      e_bpo = bp_tx;
      e_loo = lo_tx;
      lag = mark ? 0 : lag + 1;
      if (fstart) begin
        chk("boundary lag", 1, 32'(lag >= 1 && lag <= 4));
        chk("start slot", 0, {chan, bitn});
        chk("clock 8m at boundary", ocs, clk8);
        chk("clock 16m at boundary", ocs, clk16);
        chk("pulse 8m at boundary", sty, fp8);
        chk("pulse 16m at boundary", sty, fp16);
        chk("style", {1'b1, sty}, {locked, style});
        if (frames > 0) begin
          chk("frame cycles", 2048 * HALF, f_cyc);
          chk("strobes", exp_strobes(rate), n_str);
          chk("last slot", {8'(exp_strobes(rate) / 8 - 1), 3'h7}, {last_ch, last_bit});
          chk("clock 8m rises", 1024, n_r8);
          chk("clock 16m rises", 2048, n_r16);
          chk("pulse 8m width", exp_width(frame_pulse_width_select, 2), w8);
          chk("pulse 16m width", exp_width(frame_pulse_width_select, 1), w16);
        end
        frames++;
        {f_cyc, n_str, n_r8, n_r16, w8, w16} = '0;
      end
      f_cyc++;
      if (strobe) begin
        n_str++;
        last_ch = chan;
        last_bit = bitn;
      end
      n_r8 += int'(clk8 && !c8q);
      n_r16 += int'(clk16 && !c16q);
      w8 += int'(fp8 === sty);
      w16 += int'(fp16 === sty);
    end
    c8q = clk8;
    c16q = clk16;
  end

  // ==========================================================================
  // Stimulus: random outgoing bits every cycle, one test per stream rate
  always @(posedge i_clk) begin
    #1;
    bp_tx = $random(seed);
    lo_tx = $random(seed);
  end

  initial begin
    for (int i = 0; i < 4; i++) begin
      @(posedge i_clk);
      #1;
      i_rst = 1'b1;
      rate = 2'(i);
      frame_pulse_width_select = i[0];
      ies = i[1];
      ocs = i[0] ^ i[1];
      sty = 1'($random(seed));
      repeat (10) @(posedge i_clk);
      #1;
      i_rst = 1'b0;
      // Freeze just after reset: with the clock enable low no output may move.
      repeat (2) @(posedge i_clk);
      #1;
      i_ce = 1'b0;
      hold8 = clk8;
      hold16 = clk16;
      repeat (6) begin
        @(posedge i_clk);
        #1;
        chk("clock 8m frozen", hold8, clk8);
        chk("clock 16m frozen", hold16, clk16);
        chk("locked during freeze", 0, locked);
      end
      i_ce = 1'b1;
      for (int k = 0; k < 20000 && frames < 2; k++) @(posedge i_clk);
      chk("frames seen", 1, 32'(frames >= 2));
      $display("test %0d done: rate %0d wide %0d style %0d", i, rate, frame_pulse_width_select, sty);
    end
    results();
  end
endmodule // tb_top

// File: bench/tft_far_end.sv
/*
  Far-end model: master clock, frame pulse and the 64 input streams of external TDM gear.
  Assumes i_clk is the 125 MHz system clock; HALF is the master half period in cycles.
*/
`timescale 1ns/100ps
module tft_far_end #(
  parameter int HALF = 4
) (
  input  wire logic        i_clk,
  input  wire logic        i_edge_sel,
  input  wire logic        i_wide,
  input  wire logic        i_active_high,
  input  wire logic [1:0]  i_rate,
  output logic             o_master_clock,
  output logic             o_frame_pulse,
  output logic             o_frame_mark,
  output logic      [31:0] o_backplane_serial,
  output logic      [31:0] o_local_serial
);
  // ==========================================================================
  // Free-running master timing
  int          ph = 0;
  int          seed = 47300;
  logic [9:0]  per = 10'h000;
  logic        half = 1'b0;
  logic        act;
  logic [10:0] mask;

  initial begin
    o_master_clock = 1'b0;
    o_frame_pulse = 1'b1;
    o_frame_mark = 1'b0;
    o_backplane_serial = 32'h0;
    o_local_serial = 32'h0;
  end

  // Everything moves 1 ns after the edge, so the design never races the model.
  always @(posedge i_clk) begin
    #1;
    o_frame_mark = 1'b0;
    ph = ph + 1;
    if (ph == HALF) begin
      ph = 0;
      o_master_clock = ~o_master_clock;
      if (o_master_clock == i_edge_sel) begin
        per = per + 10'h001;
        half = 1'b0;
        o_frame_mark = (per == 10'h000);
      end else begin
        half = 1'b1;
        // The pulse straddles the boundary edge: one period narrow, two wide.
        act = (per == 10'h3ff) || (i_wide && per == 10'h3fe);
        o_frame_pulse = act ? i_active_high : ~i_active_high;
      end
      mask = 11'((1 << (3 - i_rate)) - 1);
      if (({per, half} & mask) == 11'h000) begin
        o_backplane_serial = $random(seed);
        o_local_serial = $random(seed);
      end
    end
  end
endmodule // tft_far_end

// File: hdl/tft_frame_timing.sv
/*
  Frame timing front end: master clock edge detection, frame-pulse style detection,
  frame boundary, bit and channel counters, output clocks and frame pulses, and the
  backplane and local stream lanes.
  Assumes all inputs are synchronous to i_clk, which runs far faster than the
  8.192 MHz master clock so every master edge is seen as a level change.
*/
`timescale 1ns/100ps
module tft_frame_timing (
  input  wire logic                        i_clk,
  input  wire logic                        i_rst,
  input  wire logic                        i_ce,
  input  wire logic                        i_master_clock_in,
  input  wire logic                        i_frame_pulse_in,
  input  wire logic                        i_input_clock_edge_select,
  input  wire logic                        i_frame_pulse_width_select,
  input  wire logic                        i_output_clock_edge_select,
  input  wire logic [1:0]                  i_stream_rate,
  input  wire logic [tft_pkg::STREAMS-1:0] i_backplane_serial_in,
  input  wire logic [tft_pkg::STREAMS-1:0] i_local_serial_in,
  input  wire logic [tft_pkg::STREAMS-1:0] i_backplane_tx_bits,
  input  wire logic [tft_pkg::STREAMS-1:0] i_local_tx_bits,
  output logic      [tft_pkg::STREAMS-1:0] o_backplane_rx_bits,
  output logic      [tft_pkg::STREAMS-1:0] o_local_rx_bits,
  output logic      [tft_pkg::STREAMS-1:0] o_backplane_serial_out,
  output logic      [tft_pkg::STREAMS-1:0] o_local_serial_out,
  output logic                             o_clock_out_8m,
  output logic                             o_frame_pulse_out_8m,
  output logic                             o_clock_out_16m,
  output logic                             o_frame_pulse_out_16m,
  output logic                             o_style_active_high,
  output logic                             o_locked,
  output logic                             o_frame_start,
  output logic                             o_bit_strobe,
  output logic      [tft_pkg::CHAN_W-1:0]  o_channel,
  output logic      [tft_pkg::BIT_W-1:0]   o_bit
);

  // ==========================================================================
  // State
  typedef struct packed {
    tft_pkg::tft_det_type      det;
    logic                      mclk_prev;
    logic                      fp_last;
    logic [1:0]                run;
    logic                      idle_lvl;
    logic [1:0]                act_run;
    logic [7:0]                hp_cnt;
    logic [7:0]                hp_len;
    logic [tft_pkg::MC_W-1:0]  mc;
    logic                      half;
    logic [2:0]                e_cnt;
    logic                      framed;
    logic                      c8;
    logic                      c16;
    logic                      fp8;
    logic                      fp16;
    logic                      frame_start;
    logic                      strobe;
    logic [tft_pkg::CHAN_W-1:0] chan;
    logic [tft_pkg::BIT_W-1:0] bitn;
  } tft_state_type;

  tft_state_type st_reg;
  tft_state_type st_next;

  logic                       edge_seen;
  logic                       sel_edge;
  logic                       mid_point;
  logic                       fp_active;
  logic                       boundary;
  logic [1:0]                 win;
  logic [2:0]                 w8;
  logic [2:0]                 w16;
  logic [1:0]                 shift;
  logic [tft_pkg::IDX_W-1:0]  idx;
  logic [tft_pkg::IDX_W-1:0]  low_mask;
  logic [tft_pkg::IDX_W-1:0]  bit_index;

  // ==========================================================================
  // Edge and pulse decoding
  always_comb begin
    edge_seen = i_master_clock_in != st_reg.mclk_prev;
    // The boundary edge is rising when the select bit is high, falling when low.
    sel_edge = edge_seen && (i_master_clock_in == i_input_clock_edge_select); // R01
    // Toggle one cycle early, since the registered 16 MHz clock shows the toggle a cycle late.
    mid_point = !edge_seen && (st_reg.hp_len > 8'h1) && ((st_reg.hp_cnt + 8'h1) == (st_reg.hp_len >> 1));
    win = i_frame_pulse_width_select ? tft_pkg::WIN_WIDE : tft_pkg::WIN_NARROW; // R02
    w8 = i_frame_pulse_width_select ? tft_pkg::W8_WIDE : tft_pkg::W8_NARROW;
    w16 = i_frame_pulse_width_select ? tft_pkg::W16_WIDE : tft_pkg::W16_NARROW;
    fp_active = (st_reg.det == tft_pkg::DET_LOCKED) && (i_frame_pulse_in != st_reg.idle_lvl);
    boundary = sel_edge && fp_active && ((st_reg.act_run + 2'h1) == win); // R02
    unique case (i_stream_rate) // R09
      tft_pkg::RATE_2M:  shift = 2'h3;
      tft_pkg::RATE_4M:  shift = 2'h2;
      tft_pkg::RATE_8M:  shift = 2'h1;
      tft_pkg::RATE_16M: shift = 2'h0;
    endcase
    low_mask = tft_pkg::IDX_W'((1 << shift) - 1);
  end

  // ==========================================================================
  // Next state
  always_comb begin
    st_next = st_reg;
    st_next.mclk_prev = i_master_clock_in;
    st_next.frame_start = 1'b0;
    st_next.strobe = 1'b0;
    idx = {st_reg.mc, st_reg.half};
    bit_index = '0;

    // Half-period measure drives the mid-point toggle of the 16 MHz clock.
    if (edge_seen) begin
      st_next.hp_cnt = 8'h0;
      st_next.hp_len = st_reg.hp_cnt + 8'h1;
    end else if (st_reg.hp_cnt != tft_pkg::HP_SAT) begin
      st_next.hp_cnt = st_reg.hp_cnt + 8'h1;
    end

    // Style detection: a level held several boundary edges running is the idle level.
    if (sel_edge) begin
      st_next.fp_last = i_frame_pulse_in;
      if (i_frame_pulse_in == st_reg.fp_last) begin
        if (st_reg.run != tft_pkg::IDLE_RUN) begin
          st_next.run = st_reg.run + 2'h1;
        end
      end else begin
        st_next.run = 2'h0;
      end
      if (st_reg.run == tft_pkg::IDLE_RUN && i_frame_pulse_in == st_reg.fp_last) begin
        st_next.idle_lvl = i_frame_pulse_in; // R03
        st_next.det = tft_pkg::DET_LOCKED;   // R03
      end
      st_next.act_run = fp_active ? st_reg.act_run + 2'h1 : 2'h0;
    end

    // Counters restart on the boundary edge.
    if (boundary) begin
      st_next.mc = '0;        // R11
      st_next.half = 1'b0;
      st_next.e_cnt = 3'h0;
      st_next.framed = 1'b1;
      st_next.frame_start = 1'b1;
      st_next.act_run = 2'h0;
    end else if (edge_seen) begin
      st_next.half = !sel_edge;
      if (sel_edge) begin
        st_next.mc = st_reg.mc + tft_pkg::MC_W'(1); // R11
      end
      if (st_reg.e_cnt != tft_pkg::EDGE_SAT) begin
        st_next.e_cnt = st_reg.e_cnt + 3'h1;
      end
    end

    if (edge_seen && st_reg.framed || boundary) begin
      idx = {st_next.mc, st_next.half};
      bit_index = idx >> shift;
      st_next.strobe = (idx & low_mask) == '0;  // R11
      st_next.chan = bit_index[tft_pkg::IDX_W-1:tft_pkg::BIT_W];
      st_next.bitn = bit_index[tft_pkg::BIT_W-1:0];
    end

    // Output clocks track the input so the chosen output edge lands on the boundary.
    st_next.c8 = i_master_clock_in ^ i_input_clock_edge_select ^ i_output_clock_edge_select; // R05
    if (edge_seen) begin
      // Each master half period is one whole 16 MHz period, so every master edge restarts it.
      st_next.c16 = i_output_clock_edge_select; // R07
    end else if (mid_point) begin
      st_next.c16 = !st_reg.c16; // R07
    end

    // Output pulses are active low unless the input style was found active high.
    st_next.fp8 = (st_next.framed && st_next.e_cnt < w8) ? !st_reg.idle_lvl : st_reg.idle_lvl; // R06
    st_next.fp16 = (st_next.framed && st_next.e_cnt < w16) ? !st_reg.idle_lvl : st_reg.idle_lvl; // R07
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      // Priming the edge detector with the pin avoids a false master edge just after reset.
      st_reg <= '{det: tft_pkg::DET_SEARCH, idle_lvl: 1'b1, fp8: 1'b1, fp16: 1'b1, fp_last: 1'b1,
                  mclk_prev: i_master_clock_in, default: '0};
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // Stream lanes: both sides share one strobe so all 64 streams stay in step.
  tft_lane_group #(.WIDTH(tft_pkg::STREAMS)) u_backplane ( // R10
    .i_clk        (i_clk),
    .i_rst        (i_rst),
    .i_ce         (i_ce),
    .i_strobe     (st_reg.strobe),
    .i_serial_in  (i_backplane_serial_in),
    .i_tx_bits    (i_backplane_tx_bits),
    .o_rx_bits    (o_backplane_rx_bits),
    .o_serial_out (o_backplane_serial_out)
  );

  tft_lane_group #(.WIDTH(tft_pkg::STREAMS)) u_local ( // R10
    .i_clk        (i_clk),
    .i_rst        (i_rst),
    .i_ce         (i_ce),
    .i_strobe     (st_reg.strobe),
    .i_serial_in  (i_local_serial_in),
    .i_tx_bits    (i_local_tx_bits),
    .o_rx_bits    (o_local_rx_bits),
    .o_serial_out (o_local_serial_out)
  );

  assign o_clock_out_8m = st_reg.c8;
  assign o_clock_out_16m = st_reg.c16;
  assign o_frame_pulse_out_8m = st_reg.fp8;
  assign o_frame_pulse_out_16m = st_reg.fp16;
  assign o_style_active_high = !st_reg.idle_lvl;
  assign o_locked = st_reg.det == tft_pkg::DET_LOCKED;
  assign o_frame_start = st_reg.frame_start;
  assign o_bit_strobe = st_reg.strobe;
  assign o_channel = st_reg.chan;
  assign o_bit = st_reg.bitn;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst || !i_ce);

  sequence s_boundary;
    i_ce && boundary;
  endsequence

  a_boundary_edge: assert property (o_frame_start |-> // R01
    $past(i_master_clock_in) == i_input_clock_edge_select &&
    $past(st_reg.mclk_prev) != i_input_clock_edge_select)
    else $error("Frame boundary off the selected master edge.");
  a_boundary_count: assert property (s_boundary |=> o_frame_start && st_reg.mc == '0) // R11
    else $error("Counters not restarted at the frame boundary.");
  a_lock_needed: assert property (o_frame_start |-> $past(o_locked)) // R03
    else $error("Boundary declared before the style was found.");
  a_pulse_width: assert property (o_frame_start |-> // R02
    $past(i_frame_pulse_in) == o_style_active_high &&
    $past(st_reg.fp_last) == (i_frame_pulse_width_select ~^ o_style_active_high))
    else $error("Boundary taken at the wrong pulse width.");
  a_fp8_style: assert property (s_boundary ##1 1'b1 |=> o_frame_pulse_out_8m == o_style_active_high) // R06
    else $error("Output frame pulse not in detected style.");
  a_clk8_align: assert property (s_boundary |=> o_clock_out_8m == i_output_clock_edge_select) // R05
    else $error("8 MHz clock edge not aligned to the boundary.");
  a_clk16_align: assert property (s_boundary |=> o_clock_out_16m == i_output_clock_edge_select) // R07
    else $error("16 MHz clock edge not aligned to the boundary.");
  a_strobe_chan: assert property (s_boundary |=> o_bit_strobe && o_channel == '0 && o_bit == '0) // R11
    else $error("First bit of frame not strobed as channel zero.");
  a_fp16_end: assert property (s_boundary ##1 (!edge_seen [*2]) |-> $stable(o_frame_pulse_out_16m)) // R07
    else $error("16 MHz frame pulse changed without a master edge.");

endmodule // tft_frame_timing

// File: hdl/tft_lane_group.sv
/*
  One group of serial lanes: samples the input streams and registers the output
  streams on a shared bit strobe.
  Assumes the strobe is a one-cycle pulse from the frame timing counters.
*/
`timescale 1ns/100ps
module tft_lane_group #(
  parameter int WIDTH = 32
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_ce,
  input  wire logic             i_strobe,
  input  wire logic [WIDTH-1:0] i_serial_in,
  input  wire logic [WIDTH-1:0] i_tx_bits,
  output logic      [WIDTH-1:0] o_rx_bits,
  output logic      [WIDTH-1:0] o_serial_out
);

  typedef struct packed {
    logic [WIDTH-1:0] rx;
    logic [WIDTH-1:0] out;
  } tft_lane_type;

  tft_lane_type st_reg;
  tft_lane_type st_next;

  always_comb begin
    st_next = st_reg;
    if (i_strobe) begin
      st_next.rx = i_serial_in;    // R04
      st_next.out = i_tx_bits;     // R08
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_reg <= '0;
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

  assign o_rx_bits = st_reg.rx;
  assign o_serial_out = st_reg.out;

  a_lane_out_hold: assert property (@(posedge i_clk) disable iff (i_rst) // R08
    !(i_ce && i_strobe) |=> $stable(o_serial_out))
    else $error("Serial output changed without a bit strobe.");

endmodule // tft_lane_group

// File: hdl/tft_pkg.sv
/*
  Shared constants and types for the TDM frame timing front end.
  Assumes one system clock at 125 MHz that samples the master clock, the frame pulse
  and the serial streams as ordinary synchronous inputs.
*/
// Behaviour
// [R01] Accept the 8.192 MHz master clock; frame boundary on the selected input edge.
// [R02] Accept an input frame pulse one or two master periods wide, chosen by width bit.
// [R03] Find the frame-pulse polarity style from the input itself, with no setting.
// [R04] The far end aligns every input stream to master clock and frame pulse.
// [R05] Generate an 8.192 MHz clock whose selected edge meets the output frame boundary.
// [R06] Emit an 8 kHz frame pulse, 122 or 244 ns, in the detected style.
// [R07] Emit a 16.384 MHz clock and 8 kHz pulse, 61 or 122 ns, polarity-aligned.
// [R08] Drive all output streams aligned to the generated clocks and frame pulses.
// [R09] Streams carry 256, 128, 64 or 32 channels at 16, 8, 4 or 2 Mbps.
// [R10] Thirty-two backplane and thirty-two local input streams share one frame timing.
// [R11] Bit and channel counters start at the frame boundary; eight bits per channel.
package tft_pkg;

  // ==========================================================================
  // Stream geometry
  localparam int STREAMS = 32;
  localparam int BITS_PER_CHANNEL = 8;
  localparam int MC_W = 10;               // Master periods per frame are 1024.
  localparam int IDX_W = MC_W + 1;        // Half-period bit index at 16 Mbps.
  localparam int CHAN_W = 8;
  localparam int BIT_W = 3;

  // ==========================================================================
  // Timing figures
  localparam int MCLK_HALF_NS = 61;       // Half period of 8.192 MHz.
  localparam int FP_NARROW_NS = 122;
  localparam int FP_WIDE_NS = 244;
  localparam int FP16_NARROW_NS = 61;
  localparam int FP16_WIDE_NS = 122;
  // Pulse widths as counts of master clock half periods.
  localparam logic [2:0] W8_NARROW = 3'(FP_NARROW_NS / MCLK_HALF_NS);
  localparam logic [2:0] W8_WIDE = 3'(FP_WIDE_NS / MCLK_HALF_NS);
  localparam logic [2:0] W16_NARROW = 3'(FP16_NARROW_NS / MCLK_HALF_NS);
  localparam logic [2:0] W16_WIDE = 3'(FP16_WIDE_NS / MCLK_HALF_NS);
  // Input pulse width in master periods.
  localparam logic [1:0] WIN_NARROW = 2'(FP_NARROW_NS / (2 * MCLK_HALF_NS));
  localparam logic [1:0] WIN_WIDE = 2'(FP_WIDE_NS / (2 * MCLK_HALF_NS));
  // Run of equal samples after the first that, matched once more, marks the idle level of the frame pulse.
  localparam logic [1:0] IDLE_RUN = 2'h3;
  localparam logic [2:0] EDGE_SAT = 3'h7;
  localparam logic [7:0] HP_SAT = 8'hff;

  // ==========================================================================
  // Stream rate codes
  localparam logic [1:0] RATE_2M = 2'h0;
  localparam logic [1:0] RATE_4M = 2'h1;
  localparam logic [1:0] RATE_8M = 2'h2;
  localparam logic [1:0] RATE_16M = 2'h3;

  typedef enum logic [0:0] {
    DET_SEARCH,
    DET_LOCKED
  } tft_det_type;

endpackage
